// ==== sad_defs.vh ====
// Address map constants for the system address decoder.
// Assumes a 32-bit byte-addressed processor bus and word-wide targets.
`ifndef SAD_DEFS_VH
`define SAD_DEFS_VH

// ********************************************************************
// Target count and target indices
// ********************************************************************
`define SAD_NTGT 28
`define SAD_IDX_FLASH 5'h00
`define SAD_IDX_SRAM 5'h01
`define SAD_IDX_WATCHDOG 5'h02
`define SAD_IDX_GPIOA 5'h03
`define SAD_IDX_GPIOB 5'h04
`define SAD_IDX_GPIOC 5'h05
`define SAD_IDX_GPIOD 5'h06
`define SAD_IDX_SYNC_SERIAL_PORT0 5'h07
`define SAD_IDX_ASYNC_SERIAL_PORT0 5'h08
`define SAD_IDX_I2C_MASTER0 5'h09
`define SAD_IDX_I2C_SLAVE0 5'h0A
`define SAD_IDX_GPIOE 5'h0B
`define SAD_IDX_GPIOF 5'h0C
`define SAD_IDX_GPIOG 5'h0D
`define SAD_IDX_GPIOH 5'h0E
`define SAD_IDX_PWM 5'h0F
`define SAD_IDX_TIMER0 5'h10
`define SAD_IDX_TIMER1 5'h11
`define SAD_IDX_TIMER2 5'h12
`define SAD_IDX_COMPARATORS 5'h13
`define SAD_IDX_CAN0 5'h14
`define SAD_IDX_FLASH_CONTROL 5'h15
`define SAD_IDX_SYSTEM_CONTROL 5'h16
`define SAD_IDX_SOFTWARE_TRACE_UNIT 5'h17
`define SAD_IDX_WATCHPOINT_TRACE_UNIT 5'h18
`define SAD_IDX_PATCH_BREAKPOINT_UNIT 5'h19
`define SAD_IDX_VECTORED_INTERRUPT_CONTROLLER 5'h1A
`define SAD_IDX_TRACE_PORT_UNIT 5'h1B

// ********************************************************************
// Window bases and offset masks (all windows are size aligned)
// ********************************************************************
`define SAD_FLASH_BASE 32'h00000000
`define SAD_FLASH_MASK 32'h1FFFFFFF
`define SAD_SRAM_BASE 32'h20000000
`define SAD_SRAM_MASK 32'h000FFFFF
`define SAD_MASK_4K 32'h00000FFF
`define SAD_MASK_2K 32'h000007FF
`define SAD_WATCHDOG_BASE 32'h40000000
`define SAD_GPIOA_BASE 32'h40004000
`define SAD_GPIOB_BASE 32'h40005000
`define SAD_GPIOC_BASE 32'h40006000
`define SAD_GPIOD_BASE 32'h40007000
`define SAD_SYNC_SERIAL_PORT0_BASE 32'h40008000
`define SAD_ASYNC_SERIAL_PORT0_BASE 32'h4000C000
`define SAD_I2C_MASTER0_BASE 32'h40020000
`define SAD_I2C_SLAVE0_BASE 32'h40020800
`define SAD_GPIOE_BASE 32'h40024000
`define SAD_GPIOF_BASE 32'h40025000
`define SAD_GPIOG_BASE 32'h40026000
`define SAD_GPIOH_BASE 32'h40027000
`define SAD_PWM_BASE 32'h40028000
`define SAD_TIMER0_BASE 32'h40030000
`define SAD_TIMER1_BASE 32'h40031000
`define SAD_TIMER2_BASE 32'h40032000
`define SAD_COMPARATORS_BASE 32'h4003C000
`define SAD_CAN0_BASE 32'h40040000
`define SAD_FLASH_CONTROL_BASE 32'h400FD000
`define SAD_SYSTEM_CONTROL_BASE 32'h400FE000
`define SAD_SOFTWARE_TRACE_UNIT_BASE 32'hE0000000
`define SAD_WATCHPOINT_TRACE_UNIT_BASE 32'hE0001000
`define SAD_PATCH_BREAKPOINT_UNIT_BASE 32'hE0002000
`define SAD_VECTORED_INTERRUPT_CONTROLLER_BASE 32'hE000E000
`define SAD_TRACE_PORT_UNIT_BASE 32'hE0040000

// ********************************************************************
// Bit alias windows
// ********************************************************************
`define SAD_SRAM_ALIAS_BASE 32'h22000000
`define SAD_PERIPH_ALIAS_BASE 32'h42000000
`define SAD_ALIAS_MASK 32'h01FFFFFF
`define SAD_PERIPH_BASE 32'h40000000

// ********************************************************************
// Default implemented memory sizes in bytes
// ********************************************************************
`define SAD_FLASH_BYTES 32'h00010000
`define SAD_SRAM_BYTES 32'h00004000

// ********************************************************************
// Sequencer states
// ********************************************************************
`define SAD_ST_IDLE 2'h0
`define SAD_ST_ACC 2'h1
`define SAD_ST_GAP 2'h2

`endif

// ==== sad_bitband.v ====
// Bit alias translation and single-bit merge for the address decoder.
// Assumes the caller registers the merge inputs; this block is purely
// combinational.
`include "sad_defs.vh"

module sad_bitband (
    addr,
    isAlias,
    wordAddr,
    bitIdx,
    word,
    mergeIdx,
    mergeVal,
    merged,
    bitOut
);
    input wire [31:0] addr;      // Address presented by the master.
    output wire isAlias;         // High when addr lies in an alias window.
    output wire [31:0] wordAddr; // Aliased target word address.
    output wire [4:0] bitIdx;    // Bit position inside that word.
    input wire [31:0] word;      // Word read back from the target.
    input wire [4:0] mergeIdx;   // Bit to replace or extract.
    input wire mergeVal;         // New value of that bit.
    output wire [31:0] merged;   // Word with only that bit changed.
    output wire bitOut;          // Extracted bit of the read word.

    // ****************************************************************
    // Alias window detection
    // ****************************************************************
    // Both windows are 32 MB and size aligned, so a mask compare works.
    wire sramAlias;
    wire periphAlias;
    assign sramAlias =
        (addr & ~`SAD_ALIAS_MASK) == `SAD_SRAM_ALIAS_BASE; // [R04]
    assign periphAlias =
        (addr & ~`SAD_ALIAS_MASK) == `SAD_PERIPH_ALIAS_BASE; // [R05]
    assign isAlias = sramAlias | periphAlias;

    // ****************************************************************
    // Translation: each alias word stands for one bit of a real word
    // ****************************************************************
    // Alias bits 24:7 pick the real word, bits 6:2 the bit within it.
    assign wordAddr = (periphAlias ? `SAD_PERIPH_BASE : `SAD_SRAM_BASE) |
        {12'h000, addr[24:7], 2'h0}; // [R04] [R05]
    assign bitIdx = addr[6:2];

    // ****************************************************************
    // Merge and extract
    // ****************************************************************
    // Only the addressed bit differs between word and merged.
    assign merged = (word & ~(32'h00000001 << mergeIdx)) |
        ({31'h00000000, mergeVal} << mergeIdx); // [R18]
    assign bitOut = word[mergeIdx]; // [R18]
endmodule

// ==== sad_decoder.v ====
// System address decoder: routes each processor bus access to one target or to a bus fault.
// Assumes one master that issues a request pulse only while mBusy is
// low, and targets that answer with tReady while their select is high.
`include "sad_defs.vh"

// Operation
// [R01] Flash range routes to flash, unbacked faults
// [R02] SRAM range routes to SRAM, unbacked faults
// [R03] Reserved SRAM space always faults
// [R04] SRAM alias window maps bits of SRAM
// [R05] Peripheral alias window maps bits of peripherals
// [R06] Each peripheral owns a fixed window, offset decoded
// [R07] Future peripheral space selects no module
// [R08] Reserved peripheral space selects no target
// [R09] External device space selects nothing
// [R10] Select software trace unit window
// [R11] Select watchpoint trace unit window
// [R12] Select patch breakpoint unit window
// [R13] Select interrupt controller window
// [R14] Select trace port unit window
// [R15] Vendor space has no target
// [R16] Reserved or unlisted addresses answer bus fault
// [R17] At most one select; forward data or fault
// [R18] Alias write changes one bit; read returns it
module sad_decoder #(
    parameter [31:0] FLASH_BYTES = `SAD_FLASH_BYTES,
    parameter [31:0] SRAM_BYTES = `SAD_SRAM_BYTES
) (
    input wire clk,
    input wire nrst,
    input wire mReq,
    input wire mWrite,
    input wire [31:0] mAddr,
    input wire [31:0] mWdata,
    output reg mBusy,
    output reg mDone,
    output reg mFault,
    output reg [31:0] mRdata,
    output reg [`SAD_NTGT-1:0] tSel,
    output reg tWrite,
    output reg [31:0] tAddr,
    output reg [31:0] tWdata,
    input wire [`SAD_NTGT*32-1:0] tRdata,
    input wire [`SAD_NTGT-1:0] tReady
);
    localparam NTGT = `SAD_NTGT;

    // ****************************************************************
    // Window decode
    // ****************************************************************
    // Returns {hit, index}. Anything not listed falls through as a miss,
    // which covers the reserved SRAM space, the future and reserved
    // peripheral space, the external device space and vendor space.
    function [5:0] decodeWin;
        input [31:0] a;
        reg [5:0] r;
        begin
            r = 6'h00;
            if ((a & ~`SAD_FLASH_MASK) == `SAD_FLASH_BASE) begin
                r = {1'b1, `SAD_IDX_FLASH}; // [R01]
            end else if ((a & ~`SAD_SRAM_MASK) == `SAD_SRAM_BASE) begin
                r = {1'b1, `SAD_IDX_SRAM}; // [R02]
            end else if ((a & ~`SAD_MASK_2K) == `SAD_I2C_MASTER0_BASE) begin
                r = {1'b1, `SAD_IDX_I2C_MASTER0}; // [R06]
            end else if ((a & ~`SAD_MASK_2K) == `SAD_I2C_SLAVE0_BASE) begin
                r = {1'b1, `SAD_IDX_I2C_SLAVE0}; // [R06]
            end else begin
                // The remaining windows are all 4 KB, keyed on bits 31:12.
                case (a & ~`SAD_MASK_4K)
                    `SAD_WATCHDOG_BASE: r = {1'b1, `SAD_IDX_WATCHDOG}; // [R06]
                    `SAD_GPIOA_BASE: r = {1'b1, `SAD_IDX_GPIOA};
                    `SAD_GPIOB_BASE: r = {1'b1, `SAD_IDX_GPIOB};
                    `SAD_GPIOC_BASE: r = {1'b1, `SAD_IDX_GPIOC};
                    `SAD_GPIOD_BASE: r = {1'b1, `SAD_IDX_GPIOD};
                    `SAD_SYNC_SERIAL_PORT0_BASE:
                        r = {1'b1, `SAD_IDX_SYNC_SERIAL_PORT0};
                    `SAD_ASYNC_SERIAL_PORT0_BASE:
                        r = {1'b1, `SAD_IDX_ASYNC_SERIAL_PORT0}; // [R06]
                    `SAD_GPIOE_BASE: r = {1'b1, `SAD_IDX_GPIOE};
                    `SAD_GPIOF_BASE: r = {1'b1, `SAD_IDX_GPIOF};
                    `SAD_GPIOG_BASE: r = {1'b1, `SAD_IDX_GPIOG};
                    `SAD_GPIOH_BASE: r = {1'b1, `SAD_IDX_GPIOH};
                    `SAD_PWM_BASE: r = {1'b1, `SAD_IDX_PWM};
                    `SAD_TIMER0_BASE: r = {1'b1, `SAD_IDX_TIMER0};
                    `SAD_TIMER1_BASE: r = {1'b1, `SAD_IDX_TIMER1};
                    `SAD_TIMER2_BASE: r = {1'b1, `SAD_IDX_TIMER2};
                    `SAD_COMPARATORS_BASE: r = {1'b1, `SAD_IDX_COMPARATORS};
                    `SAD_CAN0_BASE: r = {1'b1, `SAD_IDX_CAN0};
                    `SAD_FLASH_CONTROL_BASE:
                        r = {1'b1, `SAD_IDX_FLASH_CONTROL};
                    `SAD_SYSTEM_CONTROL_BASE:
                        r = {1'b1, `SAD_IDX_SYSTEM_CONTROL}; // [R06]
                    `SAD_SOFTWARE_TRACE_UNIT_BASE:
                        r = {1'b1, `SAD_IDX_SOFTWARE_TRACE_UNIT}; // [R10]
                    `SAD_WATCHPOINT_TRACE_UNIT_BASE:
                        r = {1'b1, `SAD_IDX_WATCHPOINT_TRACE_UNIT}; // [R11]
                    `SAD_PATCH_BREAKPOINT_UNIT_BASE:
                        r = {1'b1, `SAD_IDX_PATCH_BREAKPOINT_UNIT}; // [R12]
                    `SAD_VECTORED_INTERRUPT_CONTROLLER_BASE: // [R13]
                        r = {1'b1, `SAD_IDX_VECTORED_INTERRUPT_CONTROLLER};
                    `SAD_TRACE_PORT_UNIT_BASE:
                        r = {1'b1, `SAD_IDX_TRACE_PORT_UNIT}; // [R14]
                    // Reserved and unlisted space selects nothing.
                    default: r = 6'h00; // [R03] [R07] [R08] [R09] [R15]
                endcase
            end
            decodeWin = r;
        end
    endfunction

    // Offset mask of a window, so targets see addresses from their base.
    function [31:0] winMask;
        input [4:0] i;
        begin
            case (i)
                `SAD_IDX_FLASH: winMask = `SAD_FLASH_MASK;
                `SAD_IDX_SRAM: winMask = `SAD_SRAM_MASK;
                `SAD_IDX_I2C_MASTER0: winMask = `SAD_MASK_2K;
                `SAD_IDX_I2C_SLAVE0: winMask = `SAD_MASK_2K;
                default: winMask = `SAD_MASK_4K;
            endcase
        end
    endfunction

    // ****************************************************************
    // Request side: alias translation and decode
    // ****************************************************************
    wire bbAlias;          // Request address lies in an alias window.
    wire [31:0] bbWordAddr; // Real word behind an alias address.
    wire [4:0] bbBit;      // Bit index behind an alias address.
    wire [31:0] bbMerged;  // Read word with the alias bit replaced.
    wire bbBitOut;         // Alias bit taken from the read word.
    wire [31:0] selRdata;  // Read data of the selected target.
    reg aliasOp;           // Transfer in flight goes through an alias.
    reg writeOp;           // Transfer in flight is a write.
    reg secondPhase;       // Alias write is in its write-back phase.
    reg [4:0] aliasBit;    // Stored alias bit index.
    reg aliasVal;          // Stored alias write bit.
    reg [31:0] mergedWord; // Word to write back for an alias write.
    reg [`SAD_NTGT-1:0] selSave; // Select to reuse for write-back.
    reg [1:0] state;       // Sequencer state.

    sad_bitband uBitband (
        .addr(mAddr),
        .isAlias(bbAlias),
        .wordAddr(bbWordAddr),
        .bitIdx(bbBit),
        .word(selRdata),
        .mergeIdx(aliasBit),
        .mergeVal(aliasVal),
        .merged(bbMerged),
        .bitOut(bbBitOut)
    );

    wire [31:0] reqAddr;   // Address after alias translation.
    wire [5:0] reqDec;     // Decode result {hit, index}.
    wire [31:0] reqOffset; // Offset inside the chosen window.
    wire reqBacked;        // Offset lies inside implemented memory.
    wire reqHit;           // Request selects a real target.
    wire [`SAD_NTGT-1:0] reqOneHot; // Select vector for the request.

    assign reqAddr = bbAlias ? bbWordAddr : mAddr; // [R04] [R05]
    assign reqDec = decodeWin(reqAddr);
    assign reqOffset = reqAddr & winMask(reqDec[4:0]); // [R06]
    // Flash and SRAM windows are larger than the parts fitted, so the
    // top of each window must fault rather than alias the memory.
    assign reqBacked =
        (reqDec[4:0] == `SAD_IDX_FLASH) ? (reqOffset < FLASH_BYTES) : // [R01]
        (reqDec[4:0] == `SAD_IDX_SRAM) ? (reqOffset < SRAM_BYTES) : // [R02]
        1'b1;
    assign reqHit = reqDec[5] & reqBacked; // [R16]
    // A shifted single one guarantees at most one select.
    assign reqOneHot =
        {{(NTGT-1){1'b0}}, 1'b1} << reqDec[4:0]; // [R17]

    // ****************************************************************
    // Answer side: one AND-OR stage per target
    // ****************************************************************
    // Because tSel is one-hot, OR-ing gated data yields the one answer.
    wire [31:0] rdChain [0:`SAD_NTGT];
    assign rdChain[0] = 32'h00000000;
    genvar g;
    generate
        for (g = 0; g < NTGT; g = g + 1) begin : gRd
            assign rdChain[g+1] = rdChain[g] |
                (tSel[g] ? tRdata[g*32 +: 32] : 32'h00000000); // [R17]
        end
    endgenerate
    assign selRdata = rdChain[NTGT];

    wire selReady;         // Selected target ends its wait.
    assign selReady = |(tSel & tReady); // [R17]

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    // A plain access is one target phase. An alias write is a read,
    // one idle cycle with no select, then a write of the merged word;
    // the gap keeps the two phases distinct to a target that latches
    // on the rising edge of its select.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= `SAD_ST_IDLE;
            mBusy <= 1'b0;
            mDone <= 1'b0;
            mFault <= 1'b0;
            mRdata <= 32'h00000000;
            tSel <= {NTGT{1'b0}};
            tWrite <= 1'b0;
            tAddr <= 32'h00000000;
            tWdata <= 32'h00000000;
            aliasOp <= 1'b0;
            writeOp <= 1'b0;
            secondPhase <= 1'b0;
            aliasBit <= 5'h00;
            aliasVal <= 1'b0;
            mergedWord <= 32'h00000000;
            selSave <= {NTGT{1'b0}};
        end else begin
            // Done and fault are one-cycle pulses by default.
            mDone <= 1'b0;
            mFault <= 1'b0;
            case (state)
                `SAD_ST_IDLE: begin
                    if (mReq) begin
                        if (reqHit) begin
                            // Launch the target phase.
                            state <= `SAD_ST_ACC;
                            mBusy <= 1'b1;
                            tSel <= reqOneHot; // [R17]
                            selSave <= reqOneHot;
                            // Alias writes start with a read.
                            tWrite <= mWrite & ~bbAlias; // [R18]
                            tAddr <= reqOffset; // [R06]
                            tWdata <= mWdata;
                            aliasOp <= bbAlias;
                            writeOp <= mWrite;
                            secondPhase <= 1'b0;
                            aliasBit <= bbBit;
                            aliasVal <= mWdata[0]; // [R18]
                        end else begin
                            // Reserved, unlisted or unbacked address:
                            // no select, fault answer next cycle.
                            mDone <= 1'b1; // [R16]
                            mFault <= 1'b1; // [R16]
                            mRdata <= 32'h00000000;
                        end
                    end
                end
                `SAD_ST_ACC: begin
                    // Wait states last as long as the target holds ready low.
                    if (selReady) begin
                        tSel <= {NTGT{1'b0}};
                        tWrite <= 1'b0;
                        if (aliasOp && writeOp && !secondPhase) begin
                            mergedWord <= bbMerged; // [R18]
                            state <= `SAD_ST_GAP;
                        end else begin
                            state <= `SAD_ST_IDLE;
                            mBusy <= 1'b0;
                            mDone <= 1'b1; // [R17]
                            if (aliasOp && !writeOp) begin
                                mRdata <= {31'h00000000, bbBitOut}; // [R18]
                            end else if (writeOp) begin
                                mRdata <= 32'h00000000;
                            end else begin
                                mRdata <= selRdata; // [R17]
                            end
                        end
                    end
                end
                `SAD_ST_GAP: begin
                    // Write back the word with only one bit changed.
                    state <= `SAD_ST_ACC;
                    secondPhase <= 1'b1;
                    tSel <= selSave;
                    tWrite <= 1'b1;
                    tWdata <= mergedWord; // [R18]
                end
                default: begin
                    state <= `SAD_ST_IDLE;
                    mBusy <= 1'b0;
                    tSel <= {NTGT{1'b0}};
                    tWrite <= 1'b0;
                end
            endcase
        end
    end
endmodule

// ==== sad_decoder_assertions.sv ====
// Concurrent checks on the ports of the system address decoder.
// Assumes one master that requests only while the decoder is idle.
`include "sad_defs.vh"

// ********
// Port checker
// ********
module sad_decoder_chk #(
    parameter [31:0] FLASH_BYTES = 32'h00010000,
    parameter [31:0] SRAM_BYTES = 32'h00004000
) (
    input wire clk,
    input wire nrst,
    input wire mReq,
    input wire [31:0] mAddr,
    input wire mBusy,
    input wire mDone,
    input wire mFault,
    input wire [31:0] mRdata,
    input wire [`SAD_NTGT-1:0] tSel,
    input wire tWrite,
    input wire [31:0] tAddr,
    input wire [`SAD_NTGT-1:0] tReady
);
    timeunit 1ns;
    timeprecision 1ps;
    // A request counts only when the sequencer can take it.
    wire taken = mReq && !mBusy && !mDone;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    chk_fault_shape: assert property (
        mFault |-> mDone && tSel == 0 && mRdata == 32'h0)
        else $error("fault pulse malformed");
    chk_sel_onehot: assert property ($onehot0(tSel))
        else $error("more than one target selected");
    // A waiting target must see a steady request.
    chk_sel_hold: assert property (
        tSel != 0 && (tSel & tReady) == 0 |=>
        $stable(tSel) && $stable(tAddr) && $stable(tWrite))
        else $error("select moved during wait");
    chk_sel_drop: assert property (
        (tSel & tReady) != 0 |=> tSel == 0)
        else $error("select held after ready");
    chk_flash_route: assert property (
        taken && mAddr < FLASH_BYTES |=> tSel[0] && tAddr == $past(mAddr))
        else $error("flash not selected");
    chk_sram_route: assert property (
        taken && mAddr >= 32'h20000000 && mAddr < 32'h20000000 + SRAM_BYTES
        |=> tSel[1] && tAddr == ($past(mAddr) & 32'h000FFFFF))
        else $error("sram not selected");
    chk_ext_fault: assert property (
        taken && mAddr >= 32'h60000000 && mAddr <= 32'hDFFFFFFF |=> mFault)
        else $error("external space did not fault");
    chk_vendor_fault: assert property (
        taken && mAddr >= 32'hE0100000 |=> mFault ##1 !mDone)
        else $error("vendor space did not fault");
    chk_ctrl_route: assert property (
        taken && mAddr[31:12] == 20'hE000E
        |=> tSel[26] && tAddr == ($past(mAddr) & 32'h00000FFF))
        else $error("interrupt controller not selected");
endmodule

bind sad_decoder sad_decoder_chk #(
    .FLASH_BYTES(FLASH_BYTES),
    .SRAM_BYTES(SRAM_BYTES)
) u_sad_decoder_chk (
    .clk(clk), .nrst(nrst), .mReq(mReq), .mAddr(mAddr), .mBusy(mBusy),
    .mDone(mDone), .mFault(mFault), .mRdata(mRdata), .tSel(tSel),
    .tWrite(tWrite), .tAddr(tAddr), .tReady(tReady)
);

// ==== sad_target_model.sv ====
// Behavioural model of all decoder targets, sixteen words each.
// Assumes the decoder holds select and address steady until ready.
`include "sad_defs.vh"

module sad_target_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [`SAD_NTGT-1:0] tSel,
    input wire logic tWrite,
    input wire logic [31:0] tAddr,
    input wire logic [31:0] tWdata,
    input wire logic [3:0] lag,
    output logic [`SAD_NTGT*32-1:0] tRdata,
    output logic [`SAD_NTGT-1:0] tReady
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [`SAD_NTGT][16]; // Word store of every target.
    logic [3:0] cnt; // Cycles the current phase has waited.
    // Each word starts with a value naming its target and word.
    initial begin
        for (int i = 0; i < `SAD_NTGT; i++)
            for (int j = 0; j < 16; j++)
                mem[i][j] = {8'hA5, 8'(i), 8'h00, 8'(j)};
    end
    // Unselected slots show inverted data so stale reads are caught.
    always_comb begin
        for (int i = 0; i < `SAD_NTGT; i++) begin
            tReady[i] = tSel[i] && (cnt >= lag);
            tRdata[i*32 +: 32] = tSel[i] ? mem[i][tAddr[5:2]] :
                ~mem[i][tAddr[5:2]];
        end
    end
    // The wait count restarts in every gap between phases.
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 4'h0;
        end else begin
            cnt <= (tSel == 0 || (tSel & tReady) != 0) ? 4'h0 : cnt + 4'h1;
            for (int i = 0; i < `SAD_NTGT; i++)
                if (tSel[i] && tReady[i] && tWrite)
                    mem[i][tAddr[5:2]] <= tWdata;
        end
    end
endmodule

// ==== system_address_decoder_tb.sv ====
// Self-checking bench for the system address decoder.
// Assumes the target model answers every selected target.
`include "sad_defs.vh"

module system_address_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NT = `SAD_NTGT;
    logic clk, nrst, mReq, mWrite, mBusy, mDone, mFault, tWrite;
    logic [31:0] mAddr, mWdata, mRdata, tAddr, tWdata;
    logic [NT-1:0] tSel, tReady;
    logic [NT*32-1:0] tRdata;
    logic [3:0] lag; // Ready delay of the targets.
    int err_count, total_checks, cycles;
    logic [31:0] bases [NT] = '{32'h00000000, 32'h20000000, 32'h40000000,
        32'h40004000, 32'h40005000, 32'h40006000, 32'h40007000, 32'h40008000,
        32'h4000C000, 32'h40020000, 32'h40020800, 32'h40024000, 32'h40025000,
        32'h40026000, 32'h40027000, 32'h40028000, 32'h40030000, 32'h40031000,
        32'h40032000, 32'h4003C000, 32'h40040000, 32'h400FD000, 32'h400FE000,
        32'hE0000000, 32'hE0001000, 32'hE0002000, 32'hE000E000, 32'hE0040000};
    // Unbacked, reserved and unlisted places, all of which must fault.
    logic [31:0] bad [13] = '{32'h00010000, 32'h20004000, 32'h20100000,
        32'h24000000, 32'h40001000, 32'h40010000, 32'h40120000, 32'h44000000,
        32'h60000000, 32'hE0003000, 32'hE0100000, 32'hFFFFFFFC, 32'h22080000};

    sad_decoder u_sad_decoder (.clk(clk), .nrst(nrst), .mReq(mReq),
        .mWrite(mWrite), .mAddr(mAddr), .mWdata(mWdata), .mBusy(mBusy),
        .mDone(mDone), .mFault(mFault), .mRdata(mRdata), .tSel(tSel),
        .tWrite(tWrite), .tAddr(tAddr), .tWdata(tWdata), .tRdata(tRdata),
        .tReady(tReady));
    sad_target_model u_sad_target_model (.clk(clk), .nrst(nrst),
        .tSel(tSel), .tWrite(tWrite), .tAddr(tAddr), .tWdata(tWdata),
        .lag(lag), .tRdata(tRdata), .tReady(tReady));

    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    // A hung transfer ends the run as a failure.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end

    function automatic logic [31:0] pat(input int i, input int k);
        return {8'hA5, 8'(i), 8'h00, 8'(k)};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One pulse request; the idle cycle after mDone keeps spacing safe.
    task automatic acc(input logic w, input logic [31:0] a, d, exp,
                       input logic ef);
        mReq = 1;
        mWrite = w;
        mAddr = a;
        mWdata = d;
        do begin
            @(posedge clk);
            #1;
            mReq = 0;
        end while (mDone !== 1'b1);
        check({31'h0, mFault}, {31'h0, ef});
        check(mRdata, exp);
        check({31'h0, mBusy}, 32'h0);
        @(posedge clk);
        #1;
    endtask

    task automatic test_routes();
        for (int i = 0; i < NT; i++) begin
            lag = 4'(i % 4);
            acc(0, bases[i] + 32'h8, 0, pat(i, 2), 0);
            acc(1, bases[i] + 32'hC, ~pat(i, 3), 0, 0);
            acc(0, bases[i] + 32'hC, 0, ~pat(i, 3), 0);
        end
    endtask
    task automatic test_faults();
        lag = 4'h1;
        for (int j = 0; j < 13; j++) begin
            acc(0, bad[j], 0, 32'h0, 1);
            acc(1, bad[j], 32'hFFFFFFFF, 0, 1);
        end
    endtask
    // Only bit 0 of alias write data may reach the word.
    task automatic test_alias();
        lag = 4'h2;
        acc(1, 32'h20000004, 32'h0, 0, 0);
        acc(1, 32'h22000084, 32'h1, 0, 0);
        acc(0, 32'h20000004, 0, 32'h2, 0);
        acc(0, 32'h22000084, 0, 32'h1, 0);
        acc(0, 32'h22000080, 0, 32'h0, 0);
        acc(1, 32'h22000084, 32'hFFFFFFFE, 0, 0);
        acc(0, 32'h20000004, 0, 32'h0, 0);
        // Watchdog word 3 holds the inverted pattern from the route test.
        acc(1, 32'h420001FC, 32'h1, 0, 0);
        acc(0, 32'h4000000C, 0, 32'hDAFDFFFC, 0);
        acc(0, 32'h420001FC, 0, 32'h1, 0);
    endtask

    task automatic complete_run();
        $display("Checks %0d, errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        nrst = 0;
        mReq = 0;
        mWrite = 0;
        mAddr = 32'h0;
        mWdata = 32'h0;
        lag = 4'h0;
        repeat (20) @(posedge clk);
        #1 nrst = 1;
        test_routes();
        test_faults();
        test_alias();
        complete_run();
    end
endmodule
